// [core/t16_pkg.sv]
package t16_pkg;
  // device byte locations on the cpu i/o bus
  localparam logic [2:0] ADR_CNT_LO = 3'h0;
  localparam logic [2:0] ADR_CNT_HI = 3'h1;
  localparam logic [2:0] ADR_CAP_LO = 3'h2;
  localparam logic [2:0] ADR_CAP_HI = 3'h3;
  localparam logic [2:0] ADR_CTRL_A = 3'h4;
  localparam logic [2:0] ADR_CTRL_B = 3'h5;
  localparam logic [2:0] ADR_MASK = 3'h6;
  localparam logic [2:0] ADR_FLAG = 3'h7;
  // control_reg_a / control_reg_b field positions
  localparam int CRA_WGM_LSB = 0;
  localparam int CRA_CMP_SEL = 2;
  localparam int CRB_CS_LSB = 0;
  localparam int CRB_WGM_LSB = 3;
  localparam int CRB_EDGE = 6;
  localparam int CRB_FILT = 7;
  // flag and mask bit positions, and request vector index
  localparam int FB_OVF = 0;
  localparam int FB_CAP = 5;
  localparam int IV_OVF = 0;
  localparam int IV_CAP = 1;
  // waveform modes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PC_CAP = 4'ha;
  localparam logic [3:0] WGM_CTC_CAP = 4'hc;
  localparam logic [3:0] WGM_FAST_CAP = 4'he;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] PM8 = 10'h007;
  localparam logic [9:0] PM64 = 10'h03f;
  localparam logic [9:0] PM256 = 10'h0ff;
  localparam logic [9:0] PM1024 = 10'h3ff;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam int FILT_LEN = 4;
  // synchroniser lanes
  localparam int PIN_CAP = 0;
  localparam int PIN_CMP = 1;
  localparam int PIN_EXT = 2;
  // host apb registers and fields
  localparam logic [11:0] H_CMD = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam logic [11:0] H_ACK = 12'h008;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADR_LSB = 8;
  localparam int CMD_WR = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_RD_LSB = 8;
  localparam int ST_IRQ_LSB = 16;
endpackage : t16_pkg

// [core/t16_bus_if.sv]
`timescale 1ns/1ps
// 8-bit cpu i/o bus between the timer and its controller
interface t16_bus_if;
  logic [2:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [1:0] irq_req;
  logic [1:0] irq_ack;
  modport dev (input io_addr, input io_wr, input io_rd, input io_wdata, output io_rdata,
    output irq_req, input irq_ack);
  modport cpu (output io_addr, output io_wr, output io_rd, output io_wdata, input io_rdata,
    input irq_req, output irq_ack);
endinterface : t16_bus_if

// [core/t16_timer.sv]
`timescale 1ns/1ps
module t16_timer (
  input wire logic pclk,
  input wire logic presetn,
  t16_bus_if.dev bus,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic ext_tick_pin,
  output logic at_top,
  output logic at_bottom,
  output logic timer_tick
);
  import t16_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0] temp;
    logic [7:0] cra;
    logic [7:0] crb;
    logic [7:0] msk;
    logic ovf_f;
    logic cap_f;
    logic dir_dn;
    logic [PRE_W-1:0] pre;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [FILT_LEN-1:0] flt;
    logic filt;
    logic prev;
    logic [7:0] rdata;
    logic tick;
  } t16_dev_st_t;

  t16_dev_st_t st_reg;
  t16_dev_st_t st_next;
  logic [3:0] wgm;
  logic cap_top;
  logic dual;
  logic [15:0] top;
  logic tick;
  logic src;
  logic edge_ev;
  logic hit_top;
  logic hit_bot;
  logic ovf_set;
  logic cap_set;
  logic dn;

  // mode decode and sequence end
  assign wgm = {st_reg.crb[CRB_WGM_LSB+1:CRB_WGM_LSB], st_reg.cra[CRA_WGM_LSB+1:CRA_WGM_LSB]};
  assign cap_top = (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP) || (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
  assign dual = (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP);
  assign top = cap_top ? st_reg.cap : CNT_MAX;
  assign hit_top = (st_reg.cnt == top);
  assign hit_bot = (st_reg.cnt == CNT_ZERO);

  // status outputs and interrupt requests
  assign at_top = hit_top;
  assign at_bottom = hit_bot;
  assign timer_tick = st_reg.tick;
  assign bus.io_rdata = st_reg.rdata;
  assign bus.irq_req[IV_OVF] = st_reg.ovf_f & st_reg.msk[FB_OVF];
  assign bus.irq_req[IV_CAP] = st_reg.cap_f & st_reg.msk[FB_CAP];

  // next state: sync, prescale, filter, capture, count, cpu access
  always_comb begin
    st_next = st_reg;
    tick = 1'b0;
    ovf_set = 1'b0;
    cap_set = 1'b0;
    dn = 1'b0;
    // three-stage synchronisers, level accepted when stages two and three agree
    st_next.s1 = {ext_tick_pin, comparator_output, capture_input_pin};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < 3; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
    st_next.pre = st_reg.pre + PRE_W'(1);
    // tick source select
    case (st_reg.crb[CRB_CS_LSB+2:CRB_CS_LSB])
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = ((st_reg.pre & PM8) == PM8);
      CS_DIV64: tick = ((st_reg.pre & PM64) == PM64);
      CS_DIV256: tick = ((st_reg.pre & PM256) == PM256);
      CS_DIV1024: tick = ((st_reg.pre & PM1024) == PM1024);
      CS_EXT_FALL: tick = st_reg.lvl[PIN_EXT] & ~st_next.lvl[PIN_EXT];
      CS_EXT_RISE: tick = ~st_reg.lvl[PIN_EXT] & st_next.lvl[PIN_EXT];
      default: tick = 1'b0;
    endcase
    st_next.tick = tick;
    // capture source, optional four-sample filter, edge detector
    src = st_reg.cra[CRA_CMP_SEL] ? st_reg.lvl[PIN_CMP] : st_reg.lvl[PIN_CAP];
    st_next.flt = {st_reg.flt[FILT_LEN-2:0], src};
    if (st_reg.crb[CRB_FILT]) begin
      if ((&st_reg.flt) || (~|st_reg.flt)) begin
        st_next.filt = st_reg.flt[FILT_LEN-1];
      end
    end else begin
      st_next.filt = src;
    end
    st_next.prev = st_reg.filt;
    edge_ev = (st_reg.filt != st_reg.prev) && (st_reg.filt == st_reg.crb[CRB_EDGE]);
    if (edge_ev && !cap_top) begin
      st_next.cap = st_reg.cnt;
      cap_set = 1'b1;
    end
    // counter: one operation per tick
    if (tick) begin
      if (dual) begin
        dn = st_reg.dir_dn ? !hit_bot : hit_top;
        st_next.dir_dn = dn;
        st_next.cnt = dn ? st_reg.cnt - 16'h0001 : st_reg.cnt + 16'h0001;
        ovf_set = hit_bot;
      end else begin
        st_next.dir_dn = 1'b0;
        st_next.cnt = hit_top ? CNT_ZERO : st_reg.cnt + 16'h0001;
        ovf_set = (wgm == WGM_CTC_CAP) ? (st_reg.cnt == CNT_MAX) : hit_top;
      end
    end
    // cpu reads, registered onto the data bus next cycle
    if (bus.io_rd) begin
      case (bus.io_addr)
        ADR_CNT_LO: begin
          st_next.rdata = st_reg.cnt[7:0];
          st_next.temp = st_reg.cnt[15:8];
        end
        ADR_CNT_HI: st_next.rdata = st_reg.temp;
        ADR_CAP_LO: begin
          st_next.rdata = st_reg.cap[7:0];
          st_next.temp = st_reg.cap[15:8];
        end
        ADR_CAP_HI: st_next.rdata = st_reg.temp;
        ADR_CTRL_A: st_next.rdata = st_reg.cra;
        ADR_CTRL_B: st_next.rdata = st_reg.crb;
        ADR_MASK: st_next.rdata = st_reg.msk;
        ADR_FLAG: begin
          st_next.rdata = 8'h00;
          st_next.rdata[FB_OVF] = st_reg.ovf_f;
          st_next.rdata[FB_CAP] = st_reg.cap_f;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
    // cpu writes, placed last so they override counting
    if (bus.io_wr) begin
      case (bus.io_addr)
        ADR_CNT_LO: st_next.cnt = {st_reg.temp, bus.io_wdata};
        ADR_CNT_HI: st_next.temp = bus.io_wdata;
        ADR_CAP_LO: begin
          if (cap_top) begin
            st_next.cap = {st_reg.temp, bus.io_wdata};
          end
        end
        ADR_CAP_HI: st_next.temp = bus.io_wdata;
        ADR_CTRL_A: st_next.cra = bus.io_wdata;
        ADR_CTRL_B: st_next.crb = bus.io_wdata;
        ADR_MASK: st_next.msk = bus.io_wdata;
        default: st_next.temp = st_next.temp;
      endcase
    end
    // flags: a set in the same cycle wins over any clear
    st_next.ovf_f = ovf_set | (st_reg.ovf_f & ~(bus.irq_ack[IV_OVF]
      | (bus.io_wr && bus.io_addr == ADR_FLAG && bus.io_wdata[FB_OVF])));
    st_next.cap_f = cap_set | (st_reg.cap_f & ~(bus.irq_ack[IV_CAP]
      | (bus.io_wr && bus.io_addr == ADR_FLAG && bus.io_wdata[FB_CAP])));
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : t16_timer

// [core/t16_ctrl.sv]
`timescale 1ns/1ps
module t16_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  t16_bus_if.cpu bus
);
  import t16_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_STRB = 3'b010,
    S_WAIT = 3'b100
  } t16_hst_state_t;

  typedef struct packed {
    t16_hst_state_t st;
    logic [2:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rbuf;
    logic [1:0] ack;
  } t16_hst_st_t;

  t16_hst_st_t hs_reg;
  t16_hst_st_t hs_next;
  logic wen;
  logic mapped;

  // apb slave: always ready, error on unmapped word
  assign wen = psel & penable & pwrite;
  assign mapped = (paddr == H_CMD) || (paddr == H_STAT) || (paddr == H_ACK);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // cpu bus strobes come from the state register
  assign bus.io_addr = hs_reg.addr;
  assign bus.io_wdata = hs_reg.wdata;
  assign bus.io_wr = (hs_reg.st == S_STRB) & hs_reg.wr;
  assign bus.io_rd = (hs_reg.st == S_STRB) & ~hs_reg.wr;
  assign bus.irq_ack = hs_reg.ack;

  // read mux of the controller registers
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      H_CMD: begin
        prdata[CMD_DATA_LSB +: 8] = hs_reg.wdata;
        prdata[CMD_ADR_LSB +: 3] = hs_reg.addr;
        prdata[CMD_WR] = hs_reg.wr;
      end
      H_STAT: begin
        prdata[ST_BUSY] = (hs_reg.st != S_IDLE);
        prdata[ST_RD_LSB +: 8] = hs_reg.rbuf;
        prdata[ST_IRQ_LSB +: 2] = bus.irq_req;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  // one cpu bus access per command written while idle; a command written while busy is dropped
  always_comb begin
    hs_next = hs_reg;
    hs_next.ack = 2'b00;
    case (hs_reg.st)
      S_IDLE: begin
        if (wen && paddr == H_CMD) begin
          hs_next.wdata = pwdata[CMD_DATA_LSB +: 8];
          hs_next.addr = pwdata[CMD_ADR_LSB +: 3];
          hs_next.wr = pwdata[CMD_WR];
          hs_next.st = S_STRB;
        end
      end
      S_STRB: hs_next.st = S_WAIT;
      S_WAIT: begin
        if (!hs_reg.wr) begin
          hs_next.rbuf = bus.io_rdata;
        end
        hs_next.st = S_IDLE;
      end
      default: hs_next.st = S_IDLE;
    endcase
    // interrupt-executed pulses
    if (wen && paddr == H_ACK) begin
      hs_next.ack = pwdata[1:0];
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_reg <= '{st: S_IDLE, addr: 3'h0, wr: 1'b0, wdata: 8'h00, rbuf: 8'h00, ack: 2'b00};
    end else begin
      hs_reg <= hs_next;
    end
  end
endmodule : t16_ctrl

// [verification/t16_properties.sv]
`timescale 1ns/1ps
module t16_properties import t16_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [1:0] irq_req,
  input wire logic [1:0] irq_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // strobe shape on the cpu bus
  a_strobe_excl: assert property (!(io_wr && io_rd)) else $error("read and write strobe together");
  a_wr_one_cycle: assert property (io_wr |=> !io_wr) else $error("write strobe longer than a cycle");
  a_rd_one_cycle: assert property (io_rd |=> !io_rd) else $error("read strobe longer than a cycle");
  // read data only moves after a read
  a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata)) else $error("read data moved");
  // flag clearing and masking of the requests
  a_ack_cap_clear: assert property (irq_ack[IV_CAP] |=> !irq_req[IV_CAP]) else $error("capture ack");
  a_ack_ovf_clear: assert property (irq_ack[IV_OVF] |=> !irq_req[IV_OVF]) else $error("overflow ack");
  a_flag_one_clear: assert property (io_wr && io_addr == ADR_FLAG && io_wdata[FB_CAP]
    |=> !irq_req[IV_CAP]) else $error("capture flag write one");
  a_mask_cap_off: assert property (io_wr && io_addr == ADR_MASK && !io_wdata[FB_CAP]
    |=> !irq_req[IV_CAP]) else $error("capture mask off");
  a_mask_ovf_off: assert property (io_wr && io_addr == ADR_MASK && !io_wdata[FB_OVF]
    |=> !irq_req[IV_OVF]) else $error("overflow mask off");
endmodule : t16_properties

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import t16_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, s;
  logic pready, pslverr, e, at_top, at_bottom, timer_tick;
  logic cap_pin = 1'b0, cmp_out = 1'b0, ext_pin = 1'b0;
  logic [7:0] r;
  int mismatches = 0, num_checks = 0;
  int ticks_seen = 0;
  t16_bus_if bus_if();
  t16_ctrl u_t16_ctrl(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
  t16_timer u_t16_timer(.pclk(pclk), .presetn(presetn), .bus(bus_if), .capture_input_pin(cap_pin),
    .comparator_output(cmp_out), .ext_tick_pin(ext_pin), .at_top(at_top), .at_bottom(at_bottom),
    .timer_tick(timer_tick));
  t16_properties u_props(.pclk(pclk), .presetn(presetn), .io_addr(bus_if.io_addr), .io_wr(bus_if.io_wr),
    .io_rd(bus_if.io_rd), .io_wdata(bus_if.io_wdata), .io_rdata(bus_if.io_rdata),
    .irq_req(bus_if.irq_req), .irq_ack(bus_if.irq_ack));
  always #12.5 pclk = ~pclk;
  // count the tick pulses shown on the timer_tick output
  always @(posedge pclk) begin
    if (timer_tick === 1'b1) begin
      ticks_seen <= ticks_seen + 1;
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task chk(input string n, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one apb transfer, request held until pready
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    s = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one byte access on the device bus through the command register
  task dev(input logic w, input logic [2:0] loc, input logic [7:0] d);
    apb(H_CMD, 1'b1, {15'h0000, w, 5'h00, loc, d});
    s = 32'h1;
    while (s[ST_BUSY] !== 1'b0) apb(H_STAT, 1'b0, 32'h0);
    r = s[ST_RD_LSB +: 8];
  endtask : dev
  task wr16(input logic [2:0] loc, input logic [15:0] v);
    dev(1'b1, loc + 3'h1, v[15:8]);
    dev(1'b1, loc, v[7:0]);
  endtask : wr16
  task rchk(input string n, input logic [2:0] loc, input logic [15:0] x);
    logic [7:0] l;
    dev(1'b0, loc, 8'h00);
    l = r;
    dev(1'b0, loc + 3'h1, 8'h00);
    chk(n, x, {r, l});
  endtask : rchk
  task fchk(input int b, input logic x);
    dev(1'b0, ADR_FLAG, 8'h00);
    chk("flag", {15'h0, x}, {15'h0, r[b]});
  endtask : fchk
  task schk(input int b, input logic x);
    apb(H_STAT, 1'b0, 32'h0);
    chk("irq", {15'h0, x}, {15'h0, s[b]});
  endtask : schk
  task t_count_rw;
    chk("bottom", 16'h1, {15'h0, at_bottom});
    rchk("count", ADR_CNT_LO, 16'h0000);
    wr16(ADR_CNT_LO, 16'h01ff);
    cyc(20);
    rchk("count", ADR_CNT_LO, 16'h01ff);
    dev(1'b1, ADR_CAP_LO, 8'hbb);
    rchk("capture", ADR_CAP_LO, 16'h0000);
    dev(1'b1, ADR_CTRL_A, 8'h02);
    dev(1'b1, ADR_CTRL_B, 8'h18);
    dev(1'b1, ADR_CNT_HI, 8'h12);
    dev(1'b1, ADR_CNT_LO, 8'h34);
    dev(1'b1, ADR_CAP_LO, 8'h56);
    rchk("count", ADR_CNT_LO, 16'h1234);
    rchk("capture", ADR_CAP_LO, 16'h1256);
    dev(1'b1, ADR_CTRL_A, 8'h00);
  endtask : t_count_rw
  task ext_tick(input int n);
    repeat (n) begin
      ext_pin <= 1'b1;
      cyc(8);
      ext_pin <= 1'b0;
      cyc(8);
    end
  endtask : ext_tick
  task t_ticks;
    wr16(ADR_CNT_LO, 16'h00fe);
    dev(1'b1, ADR_CTRL_B, {5'h00, CS_EXT_RISE});
    ext_tick(3);
    rchk("count", ADR_CNT_LO, 16'h0101);
    wr16(ADR_CNT_LO, 16'hffff);
    chk("top", 16'h1, {15'h0, at_top});
    dev(1'b1, ADR_MASK, 8'h21);
    ext_tick(1);
    chk("bottom", 16'h1, {15'h0, at_bottom});
    fchk(FB_OVF, 1'b1);
    schk(ST_IRQ_LSB + IV_OVF, 1'b1);
    apb(H_ACK, 1'b1, 32'h3);
    fchk(FB_OVF, 1'b0);
    dev(1'b1, ADR_CTRL_B, 8'h40);
  endtask : t_ticks
  // dual slope to capture top on falling external ticks: 2,3,2,1 then 0,1
  task t_dual;
    int t0;
    dev(1'b1, ADR_CTRL_B, {3'h0, 2'h2, CS_EXT_FALL});
    wr16(ADR_CAP_LO, 16'h0003);
    wr16(ADR_CNT_LO, 16'h0002);
    t0 = ticks_seen;
    ext_tick(3);
    chk("ticks", 16'h0003, 16'(ticks_seen - t0));
    rchk("count", ADR_CNT_LO, 16'h0001);
    fchk(FB_OVF, 1'b0);
    ext_tick(2);
    rchk("count", ADR_CNT_LO, 16'h0001);
    fchk(FB_OVF, 1'b1);
    dev(1'b1, ADR_FLAG, 8'h01);
    fchk(FB_OVF, 1'b0);
    dev(1'b1, ADR_CTRL_B, 8'h40);
  endtask : t_dual
  task pin_cap(input logic [15:0] cnt, input logic v, input logic x);
    wr16(ADR_CNT_LO, cnt);
    dev(1'b1, ADR_FLAG, 8'h21);
    cap_pin <= v;
    cyc(12);
    fchk(FB_CAP, x);
  endtask : pin_cap
  task t_capture;
    pin_cap(16'h4321, 1'b1, 1'b1);
    rchk("capture", ADR_CAP_LO, 16'h4321);
    pin_cap(16'h1111, 1'b0, 1'b0);
    rchk("capture", ADR_CAP_LO, 16'h4321);
    pin_cap(16'h2222, 1'b1, 1'b1);
    schk(ST_IRQ_LSB + IV_CAP, 1'b1);
    apb(H_ACK, 1'b1, 32'h2);
    schk(ST_IRQ_LSB + IV_CAP, 1'b0);
    dev(1'b1, ADR_CTRL_A, 8'h04);
    wr16(ADR_CNT_LO, 16'h3333);
    dev(1'b1, ADR_FLAG, 8'h21);
    cmp_out <= 1'b1;
    cyc(12);
    fchk(FB_CAP, 1'b1);
    rchk("capture", ADR_CAP_LO, 16'h3333);
    dev(1'b1, ADR_CTRL_A, 8'h00);
    dev(1'b1, ADR_CTRL_B, 8'hc0);
    pin_cap(16'h0a0a, 1'b0, 1'b0);
    cap_pin <= 1'b1;
    cyc(2);
    cap_pin <= 1'b0;
    cyc(16);
    fchk(FB_CAP, 1'b0);
    cap_pin <= 1'b1;
    cyc(16);
    fchk(FB_CAP, 1'b1);
    rchk("capture", ADR_CAP_LO, 16'h0a0a);
    dev(1'b1, ADR_MASK, 8'h00);
    apb(12'h00c, 1'b0, 32'h0);
    chk("slverr", 16'h1, {15'h0, e});
  endtask : t_capture
  task end_of_test;
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(4);
    t_count_rw();
    t_ticks();
    t_dual();
    t_capture();
    end_of_test();
  end
  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end
endmodule : testbench
